// [rtl/wdb_pkg.sv]
// Notes on behaviour
// - Each shutdown source has its own enable bit, and a clear bit blocks it.
// - Enable bit 2 lets the second comparator raise a shutdown event.
// - Enable bit 1 lets the first comparator raise a shutdown event.
// - A falling count N of 1 to 63 delays by N+1 to N+2 clock periods.
// - A rising count in bits 5 to 0 delays the output after a rising edge.
// - Bits 7 and 6 of both count registers drop writes and read as zero.
// - Count fields and shutdown enables clear to zero at every reset.
// - In shutdown the state control gives output A 11 high, 10 low, 01 off, 00 idle; B sits at its polarity bit.
// - After status clears, shutdown holds until the next data rising edge.
package wdb_pkg;

  // ==========================================================
  // Register map
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_SRC_EN = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_RISE_CNT = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_FALL_CNT = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 3'h5;

  // ==========================================================
  // Field layout
  localparam int CNT_W = 6;
  localparam int SRC_W = 5;
  localparam int BIT_PIN_EN = 0;
  localparam int BIT_CMP1_EN = 1;
  localparam int BIT_CMP2_EN = 2;
  localparam int BIT_SRC3_EN = 3;
  localparam int BIT_SRC4_EN = 4;
  localparam int BIT_POL_A = 0;
  localparam int BIT_POL_B = 1;
  localparam int BIT_STATE_LO = 2;
  localparam int BIT_SHUTDOWN = 7;
  localparam int IRQ_W = 3;
  localparam int IRQ_SHUTDOWN = 0;
  localparam int IRQ_RISE_DONE = 1;
  localparam int IRQ_FALL_DONE = 2;

  // ==========================================================
  // Shutdown output states
  typedef enum logic [1:0] {
    WDB_SD_IDLE = 2'h0,
    WDB_SD_OFF = 2'h1,
    WDB_SD_LOW = 2'h2,
    WDB_SD_HIGH = 2'h3
  } wdb_sd_state_t;

  // ==========================================================
  // Values after reset
  localparam logic [SRC_W-1:0] RST_SRC_EN = 5'h00;
  localparam logic [CNT_W-1:0] RST_CNT = 6'h00;
  localparam logic [1:0] RST_POL = 2'h0;
  localparam logic [1:0] RST_SD_STATE = 2'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;
  localparam logic [DATA_W-1:0] RST_RDATA = 8'h00;

endpackage

// [rtl/wdb_delay_counter.sv]
`timescale 1ns/1ps

// Down counter timing one dead-band interval
module wdb_delay_counter
  import wdb_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic cancel,
  input wire logic [wdb_pkg::CNT_W-1:0] count,
  output logic idle,
  output logic finish
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic busy_q;
  logic busy_d;
  logic finish_q;
  logic finish_d;

  // ==========================================================
  // Count control
  // Zero count bypasses: busy never rises, the edge passes at once
  always_comb
  begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    finish_d = 1'b0;
    if (cancel)
    begin
      busy_d = 1'b0;
    end
    else if (start)
    begin
      cnt_d = count;
      busy_d = (count != RST_CNT);
    end
    else if (busy_q)
    begin
      cnt_d = cnt_q - 6'h01;
      if (cnt_q == 6'h01)
      begin
        busy_d = 1'b0;
        finish_d = 1'b1;
      end
    end
  end

  // Count registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cnt_q <= RST_CNT;
      busy_q <= 1'b0;
      finish_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      finish_q <= finish_d;
    end
  end

  assign idle = ~busy_q;
  assign finish = finish_q;

endmodule

// [rtl/wdb_top.sv]
`timescale 1ns/1ps

// Dead-band timing and auto-shutdown source selection
module wdb_top
  import wdb_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [wdb_pkg::ADDR_W-1:0] regAddr,
  input wire logic [wdb_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [wdb_pkg::DATA_W-1:0] regRdata,
  input wire logic genDataIn,
  input wire logic shutdownPinSelectInput,
  input wire logic cmp1Out,
  input wire logic cmp2Out,
  input wire logic src3In,
  input wire logic logicCellFourOut,
  output logic outA,
  output logic outAEn,
  output logic outB,
  output logic outBEn,
  output logic shutdownRequest,
  output logic shutdownActive,
  output logic irq
);

  // ==========================================================
  // Declarations
  logic [SRC_W-1:0] srcEn_q;
  logic [SRC_W-1:0] srcEn_d;
  logic [CNT_W-1:0] riseDelayCount_q;
  logic [CNT_W-1:0] riseDelayCount_d;
  logic [CNT_W-1:0] fallDelayCount_q;
  logic [CNT_W-1:0] fallDelayCount_d;
  logic [1:0] pol_q;
  logic [1:0] pol_d;
  wdb_sd_state_t outAcShutdownState_q;
  wdb_sd_state_t outAcShutdownState_d;
  logic sdStatus_q;
  logic sdStatus_d;
  logic sdHold_q;
  logic sdHold_d;
  logic [IRQ_W-1:0] irqStat_q;
  logic [IRQ_W-1:0] irqStat_d;
  logic [IRQ_W-1:0] irqMask_q;
  logic [IRQ_W-1:0] irqMask_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic dataPrev_q;
  logic dataPrev_d;
  logic effPrev_q;
  logic effPrev_d;
  logic outA_q;
  logic outA_d;
  logic outAEn_q;
  logic outAEn_d;
  logic outB_q;
  logic outB_d;
  logic outBEn_q;
  logic outBEn_d;
  logic sdReq_q;
  logic [SRC_W-1:0] srcVec;
  logic sdEvent;
  logic dataRise;
  logic effData;
  logic effRise;
  logic effFall;
  logic riseIdle;
  logic fallIdle;
  logic riseFinish;
  logic fallFinish;
  logic ctrlWr;
  logic statusClr;
  logic [IRQ_W-1:0] irqEvents;

  // Write decode shared by several register groups
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================================
  // Shutdown source gating
  // Vector order matches the enable bit order
  always_comb
  begin
    srcVec = '0;
    srcVec[BIT_PIN_EN] = shutdownPinSelectInput;
    srcVec[BIT_CMP1_EN] = cmp1Out;
    srcVec[BIT_CMP2_EN] = cmp2Out;
    srcVec[BIT_SRC3_EN] = src3In;
    srcVec[BIT_SRC4_EN] = logicCellFourOut;
  end

  // A disabled source cannot reach the request at all
  assign sdEvent = |(srcVec & srcEn_q);

  // ==========================================================
  // Register writes
  assign ctrlWr = regWr && hit(regAddr, OFS_CTRL);
  assign statusClr = ctrlWr && !regWdata[BIT_SHUTDOWN];

  always_comb
  begin
    srcEn_d = srcEn_q;
    riseDelayCount_d = riseDelayCount_q;
    fallDelayCount_d = fallDelayCount_q;
    pol_d = pol_q;
    outAcShutdownState_d = outAcShutdownState_q;
    irqMask_d = irqMask_q;
    if (regWr)
    begin
      case (regAddr)
        OFS_SRC_EN:
          srcEn_d = regWdata[SRC_W-1:0];
        OFS_RISE_CNT:
          riseDelayCount_d = regWdata[CNT_W-1:0];
        OFS_FALL_CNT:
          fallDelayCount_d = regWdata[CNT_W-1:0];
        OFS_CTRL:
        begin
          pol_d = regWdata[BIT_POL_B:BIT_POL_A];
          outAcShutdownState_d =
            wdb_sd_state_t'(regWdata[BIT_STATE_LO+1:BIT_STATE_LO]);
        end
        OFS_IRQ_MASK:
          irqMask_d = regWdata[IRQ_W-1:0];
        default:
          irqMask_d = irqMask_q;
      endcase
    end
  end

  // Configuration registers, all cleared by reset
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      srcEn_q <= RST_SRC_EN;
      riseDelayCount_q <= RST_CNT;
      fallDelayCount_q <= RST_CNT;
      pol_q <= RST_POL;
      outAcShutdownState_q <= WDB_SD_IDLE;
      irqMask_q <= RST_IRQ;
    end
    else
    begin
      srcEn_q <= srcEn_d;
      riseDelayCount_q <= riseDelayCount_d;
      fallDelayCount_q <= fallDelayCount_d;
      pol_q <= pol_d;
      outAcShutdownState_q <= outAcShutdownState_d;
      irqMask_q <= irqMask_d;
    end
  end

  // ==========================================================
  // Shutdown status and hold
  // A live event beats a software clear in the same cycle; the hold
  // outlasts the status until the data input rises again
  assign dataRise = genDataIn && !dataPrev_q;

  always_comb
  begin
    sdStatus_d = sdStatus_q;
    if (statusClr)
    begin
      sdStatus_d = 1'b0;
    end
    if (ctrlWr && regWdata[BIT_SHUTDOWN])
    begin
      sdStatus_d = 1'b1;
    end
    if (sdEvent)
    begin
      sdStatus_d = 1'b1;
    end
    sdHold_d = sdStatus_d | (sdHold_q & ~dataRise);
    dataPrev_d = genDataIn;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sdStatus_q <= 1'b0;
      sdHold_q <= 1'b0;
      dataPrev_q <= 1'b0;
      sdReq_q <= 1'b0;
    end
    else
    begin
      sdStatus_q <= sdStatus_d;
      sdHold_q <= sdHold_d;
      dataPrev_q <= dataPrev_d;
      sdReq_q <= sdEvent;
    end
  end

  // ==========================================================
  // Dead-band timing
  // Shutdown forces the data low so the idle state follows dead band
  assign effData = genDataIn && !sdHold_q;
  assign effRise = effData && !effPrev_q;
  assign effFall = !effData && effPrev_q;

  wdb_delay_counter riseDelay (
    .clk(clk),
    .resetn(resetn),
    .start(effRise),
    .cancel(effFall),
    .count(riseDelayCount_q),
    .idle(riseIdle),
    .finish(riseFinish)
  );

  wdb_delay_counter fallDelay (
    .clk(clk),
    .resetn(resetn),
    .start(effFall),
    .cancel(effRise),
    .count(fallDelayCount_q),
    .idle(fallIdle),
    .finish(fallFinish)
  );

  // ==========================================================
  // Output drive
  // A waits out the rising interval, B the falling one; with both
  // polarity bits clear they are never high together, which protects the bridge
  always_comb
  begin
    effPrev_d = effData;
    outA_d = (effPrev_q && riseIdle && !effFall) ^ pol_q[BIT_POL_A];
    outB_d = (!effPrev_q && fallIdle && !effRise) ^ pol_q[BIT_POL_B];
    outAEn_d = 1'b1;
    outBEn_d = 1'b1;
    if (sdHold_q)
    begin
      outB_d = pol_q[BIT_POL_B];
      case (outAcShutdownState_q)
        WDB_SD_HIGH:
          outA_d = 1'b1;
        WDB_SD_LOW:
          outA_d = 1'b0;
        WDB_SD_OFF:
        begin
          outA_d = 1'b0;
          outAEn_d = 1'b0;
        end
        default:
          outA_d = outA_d;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      effPrev_q <= 1'b0;
      outA_q <= 1'b0;
      outAEn_q <= 1'b0;
      outB_q <= 1'b0;
      outBEn_q <= 1'b0;
    end
    else
    begin
      effPrev_q <= effPrev_d;
      outA_q <= outA_d;
      outAEn_q <= outAEn_d;
      outB_q <= outB_d;
      outBEn_q <= outBEn_d;
    end
  end

  // ==========================================================
  // Interrupt status, write one to clear
  assign irqEvents = {fallFinish, riseFinish, sdEvent && !sdStatus_q};

  always_comb
  begin
    irqStat_d = irqStat_q;
    if (regWr && hit(regAddr, OFS_IRQ_STAT))
    begin
      irqStat_d = irqStat_q & ~regWdata[IRQ_W-1:0];
    end
    irqStat_d = irqStat_d | irqEvents; // Set wins over clear
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      irqStat_q <= RST_IRQ;
    end
    else
    begin
      irqStat_q <= irqStat_d;
    end
  end

  // ==========================================================
  // Register reads, data valid the cycle after the strobe
  always_comb
  begin
    rdata_d = RST_RDATA;
    if (regRd)
    begin
      case (regAddr)
        OFS_SRC_EN:
          rdata_d = {3'h0, srcEn_q};
        OFS_RISE_CNT:
          rdata_d = {2'h0, riseDelayCount_q};
        OFS_FALL_CNT:
          rdata_d = {2'h0, fallDelayCount_q};
        OFS_CTRL:
          rdata_d = {sdStatus_q, 3'h0, outAcShutdownState_q, pol_q};
        OFS_IRQ_STAT:
          rdata_d = {5'h00, irqStat_q};
        OFS_IRQ_MASK:
          rdata_d = {5'h00, irqMask_q};
        default:
          rdata_d = RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rdata_q <= RST_RDATA;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Outputs
  assign regRdata = rdata_q;
  assign outA = outA_q;
  assign outAEn = outAEn_q;
  assign outB = outB_q;
  assign outBEn = outBEn_q;
  assign shutdownRequest = sdReq_q;
  assign shutdownActive = sdHold_q;
  assign irq = |(irqStat_q & irqMask_q);

endmodule

// [tb/wdb_top_asserts.sv]
`timescale 1ns/1ps

// ====
// Port checker for dead-band timing and shutdown
module wdb_chk
  import wdb_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic genDataIn,
  input wire logic shutdownPinSelectInput,
  input wire logic cmp1Out,
  input wire logic cmp2Out,
  input wire logic src3In,
  input wire logic logicCellFourOut,
  input wire logic outA,
  input wire logic outAEn,
  input wire logic outB,
  input wire logic outBEn,
  input wire logic shutdownRequest,
  input wire logic shutdownActive,
  input wire logic irq
);
  logic [4:0] en_q, en_d, srcV;
  logic [5:0] rN_q, rN_d;
  logic [1:0] sd_q, sd_d;
  logic [1:0] pl_q, pl_d;
  logic [6:0] rAge_q, rAge_d, fAge_q, fAge_d;
  logic cR_q, cR_d, cF_q, cF_d;
  logic [5:0] fN_q, fN_d;

  assign srcV = {logicCellFourOut, src3In, cmp2Out, cmp1Out,
    shutdownPinSelectInput};

  // Shadow of settings; edges under inverted polarity are skipped
  always_comb
  begin
    en_d = en_q;
    rN_d = rN_q;
    fN_d = fN_q;
    sd_d = sd_q;
    pl_d = pl_q;
    if (regWr && regAddr == OFS_SRC_EN)
      en_d = regWdata[4:0];
    if (regWr && regAddr == OFS_RISE_CNT)
      rN_d = regWdata[5:0];
    if (regWr && regAddr == OFS_FALL_CNT)
      fN_d = regWdata[5:0];
    if (regWr && regAddr == OFS_CTRL)
      sd_d = regWdata[3:2];
    if (regWr && regAddr == OFS_CTRL)
      pl_d = regWdata[1:0];
    // Ages saturate so a long level never wraps
    rAge_d = genDataIn ? rAge_q + {6'h0, rAge_q != 7'h7f} : 7'h0;
    fAge_d = !genDataIn ? fAge_q + {6'h0, fAge_q != 7'h7f} : 7'h0;
    // Edges right after a shutdown restart late, so skip them
    cR_d = (shutdownActive || pl_d != 2'h0) ? 1'b0 : (cR_q | !genDataIn);
    cF_d = (shutdownActive || pl_d != 2'h0) ? 1'b0 : (cF_q | genDataIn);
    if (!resetn)
    begin
      en_d = 5'h0;
      rN_d = 6'h0;
      fN_d = 6'h0;
      sd_d = 2'h0;
      pl_d = 2'h0;
      rAge_d = 7'h0;
      fAge_d = 7'h0;
      cR_d = 1'b0;
      cF_d = 1'b0;
    end
  end

  // Shadow registers
  always_ff @(posedge clk)
  begin
    en_q <= en_d;
    rN_q <= rN_d;
    fN_q <= fN_d;
    sd_q <= sd_d;
    pl_q <= pl_d;
    rAge_q <= rAge_d;
    fAge_q <= fAge_d;
    cR_q <= cR_d;
    cF_q <= cF_d;
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ====
  // Properties
  a_en_readback: assert property ($past(regRd) &&
    $past(regAddr) == OFS_SRC_EN |-> regRdata == {3'h0, $past(en_q)})
    else $error("enable register read back wrong");
  a_rise_readback: assert property ($past(regRd) &&
    $past(regAddr) == OFS_RISE_CNT |-> regRdata == {2'h0, $past(rN_q)})
    else $error("rise count read back wrong");
  a_src_gate: assert property (
    shutdownRequest == $past(|(en_q & srcV)))
    else $error("shutdown request not from enabled sources");
  a_cmp1_gate: assert property (
    $past(en_q[1] & cmp1Out) |-> shutdownRequest)
    else $error("first comparator ignored");
  a_cmp2_gate: assert property (
    $past(en_q[2] & cmp2Out) |-> shutdownRequest)
    else $error("second comparator ignored");
  a_rise_delay: assert property ($rose(outA) && cR_q &&
    !shutdownActive |-> rAge_q == rN_q + 7'd2)
    else $error("rising dead band length wrong");
  a_fall_delay: assert property ($rose(outB) && cF_q &&
    !shutdownActive |-> fAge_q == fN_q + 7'd2)
    else $error("falling dead band length wrong");
  a_sd_drive: assert property (shutdownActive &&
    $past(shutdownActive) && $past(shutdownActive, 2) && sd_q != 2'h0 &&
    $past(sd_q) == sd_q |-> outAEn == (sd_q != 2'h1) &&
    (sd_q == 2'h1 || outA == sd_q[0]))
    else $error("output A wrong during shutdown");
  a_hold_release: assert property ($fell(shutdownActive) |->
    $past(genDataIn) && !$past(genDataIn, 2))
    else $error("shutdown left without a data rise");
  a_b_shutdown: assert property (shutdownActive &&
    $past(shutdownActive) && $past(pl_q) == pl_q |->
    outB == pl_q[1] && outBEn)
    else $error("output B wrong during shutdown");

  cover property ($rose(outA));
  cover property ($rose(shutdownActive));
  cover property ($fell(irq));
endmodule

bind wdb_top wdb_chk wdb_chk_inst (.clk, .resetn, .regAddr, .regWdata,
  .regWr, .regRd, .regRdata, .genDataIn, .shutdownPinSelectInput,
  .cmp1Out, .cmp2Out, .src3In, .logicCellFourOut, .outA, .outAEn, .outB,
  .outBEn, .shutdownRequest, .shutdownActive, .irq);

// [tb/wdb_gate_model.sv]
`timescale 1ns/1ps

// ====
// Gate drivers on the two output pins
module wdb_gate_model
(
  input wire logic outA,
  input wire logic outAEn,
  input wire logic outB,
  input wire logic outBEn,
  output logic gateA,
  output logic gateB
);
  // Released pin sinks to its pull-down, so the switch stays off
  assign gateA = outAEn & outA;
  assign gateB = outBEn & outB;
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps

// ====
// Self-checking bench
module testbench;
  import wdb_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic genDataIn = 1'b0;
  logic [4:0] src = 5'h0;
  logic [7:0] regRdata;
  logic outA, outAEn, outB, outBEn, shReq, shAct, irq, gateA, gateB;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 32'hf2e5;
  int mdl [8];
  int nv [4] = '{0, 1, 63, 5};
  int k, st;

  wdb_top wdb_top_inst (.clk(clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .genDataIn(genDataIn),
    .shutdownPinSelectInput(src[0]), .cmp1Out(src[1]), .cmp2Out(src[2]),
    .src3In(src[3]), .logicCellFourOut(src[4]), .outA(outA),
    .outAEn(outAEn), .outB(outB), .outBEn(outBEn),
    .shutdownRequest(shReq), .shutdownActive(shAct), .irq(irq));
  wdb_gate_model wdb_gate_model_inst (.outA(outA), .outAEn(outAEn),
    .outB(outB), .outBEn(outBEn), .gateA(gateA), .gateB(gateB));

  always #2 clk = ~clk;

  // Hang guard, far above the several hundred cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      results();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Model keeps only the implemented bits
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    if (a < 3)
      mdl[a] = v & (a == 0 ? 8'h1f : 8'h3f);
  endtask

  task automatic rdc(input logic [2:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdata, 8'(mdl[a]));
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Edges from a data change until the delayed output rises
  task automatic dly(input logic lvl);
    @(posedge clk);
    genDataIn <= lvl;
    k = 0;
    do
    begin
      @(posedge clk);
      #1 k++;
    end
    while ((lvl ? outA : outB) !== 1'b1 && k < 80);
  endtask

  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    nv[3] = 2 + $unsigned($random(seed)) % 60;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 0; a < 8; a++)
      rdc(3'(a));
    // Random contents, upper bits and unmapped places
    for (int i = 0; i < 8; i++)
    begin
      wr(3'(i % 3), 8'($random(seed)));
      wr(3'(6 + i % 2), 8'hff);
      rdc(3'(i % 3));
      rdc(3'(6 + i % 2));
    end
    wr(OFS_SRC_EN, 8'h0);
    // Boundary and random dead-band counts, fall count mirrored
    foreach (nv[j])
    begin
      wr(OFS_RISE_CNT, 8'(nv[j]));
      wr(OFS_FALL_CNT, 8'(63 - nv[j]) | 8'hc0);
      dly(1'b1);
      chk(8'(k), 8'(mdl[1] + 2));
      dly(1'b0);
      chk(8'(k), 8'(mdl[2] + 2));
    end
    // Both intervals have ended, no shutdown event yet
    mdl[4] = 6;
    rdc(OFS_IRQ_STAT);
    wr(OFS_RISE_CNT, 8'h0);
    wr(OFS_FALL_CNT, 8'h0);
    // Each source alone, under each shutdown state
    for (int i = 0; i < 5; i++)
    begin
      st = i % 4;
      wr(OFS_IRQ_MASK, 8'(i != 2));
      wr(OFS_SRC_EN, 8'(1 << i));
      wr(OFS_CTRL, 8'(st << 2));
      @(posedge clk);
      src <= 5'($random(seed)) & ~5'(1 << i);
      cyc(4);
      chk(8'({shReq, shAct}), 8'h0);
      @(posedge clk);
      src <= 5'h1f;
      cyc(6);
      chk(8'({shReq, shAct, irq}), 8'({2'h3, 1'(i != 2)}));
      chk(8'({outAEn, gateA}), 8'({1'(st != 1), 1'(st == 3)}));
      @(posedge clk);
      src <= 5'h0;
      cyc(2);
      wr(OFS_CTRL, 8'(st << 2));
      wr(OFS_IRQ_STAT, 8'h01);
      cyc(4);
      chk(8'({shAct, irq}), 8'h2);
      @(posedge clk);
      genDataIn <= 1'b1;
      cyc(4);
      chk(8'(shAct), 8'h0);
      @(posedge clk);
      genDataIn <= 1'b0;
      cyc(4);
    end
    // Inverted polarity, then a software shutdown and its release
    wr(OFS_CTRL, 8'h03);
    cyc(2);
    chk(8'({outA, outB}), 8'h2);
    wr(OFS_CTRL, 8'h83);
    mdl[3] = 8'h83;
    rdc(OFS_CTRL);
    cyc(2);
    chk(8'({shAct, outA, outB, outBEn}), 8'hf);
    chk(8'({outBEn, gateB}), 8'h3);
    wr(OFS_CTRL, 8'h03);
    cyc(2);
    chk(8'(shAct), 8'h1);
    @(posedge clk);
    genDataIn <= 1'b1;
    cyc(4);
    chk(8'({shAct, outA, outB}), 8'h1);
    // Reset in mid-run clears everything again
    wr(OFS_RISE_CNT, 8'h2a);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    foreach (mdl[a])
      mdl[a] = 0;
    for (int a = 0; a < 3; a++)
      rdc(3'(a));
    results();
  end
endmodule
